/* design/msc_pkg.sv */
// Shared constants and types for the module sideband control block
package msc_pkg;

  // Core clock
  localparam int CLK_NS = 4;

  // Least reset pulse on the reset pin, and the cycles it takes (rounded up)
  localparam int RST_MIN_NS = 2000;
  localparam logic [15:0] RST_CYC = 16'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);

  // Management interface start-up time after reset (rounded up)
  localparam int INIT_NS = 1000;
  localparam logic [15:0] INIT_CYC = 16'((INIT_NS + CLK_NS - 1) / CLK_NS);

  // 2-wire device address (value is arbitrary)
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // APB byte offsets
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h000;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h004;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h008;
  localparam logic [11:0] OFS_STATE = 12'h00c;
  localparam logic [11:0] OFS_CONTROL = 12'h010;

  // Interrupt event bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_RESET_DONE = 0;
  localparam int IRQ_HOST_WRITE = 1;
  localparam int IRQ_HIGH_POWER = 2;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 3'h0;

  // CONTROL register field
  localparam int CTRL_FAULT = 0;

  // STATE register fields
  localparam int ST_NOT_READY = 0;
  localparam int ST_HIGH_POWER = 1;
  localparam int ST_INIT_SEL = 2;
  localparam int ST_SELECTED = 3;
  localparam int ST_RESET_PIN = 4;
  localparam int ST_READY = 5;

  // Byte addresses of the memory map seen over the 2-wire bus
  localparam logic [7:0] MAP_STATUS = 8'h00;
  localparam logic [7:0] MAP_CONTROL = 8'h01;
  localparam logic [7:0] MAP_ALERT = 8'h02;

  // Sequencer and 2-wire slave states
  typedef enum logic {SEQ_INIT, SEQ_READY} msc_seq_e;
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_ACK_A, TW_PTR, TW_ACK_P, TW_WDATA, TW_ACK_D, TW_RDATA
  } msc_tw_e;
  localparam logic [3:0] TW_BYTE_BITS = 4'h8;
  localparam logic [3:0] TW_LAST_BIT = 4'h7;

endpackage

/* design/msc_top.sv */
// Sideband control of a pluggable module: reset, init mode, alert, 2-wire map, APB
//
// Behaviour
// RULE_01 - Answer 2-wire traffic only while module select is held low.
// RULE_02 - Host gives each module on a shared bus its own select line.
// RULE_03 - Host reads and writes the memory map over the 2-wire bus.
// RULE_04 - Reset pin held low past the minimum length resets all settings.
// RULE_05 - Host ignores status bits until reset completion is signalled.
// RULE_06 - Completion shown by alert asserted with not-ready flag negated.
// RULE_07 - After power-up the completion alert is posted without a reset pulse.
// RULE_08 - Init select input is pulled high, so undriven means software control.
// RULE_09 - Init select high keeps low power until software enables high power.
// RULE_10 - Init select low lets the module enter high power once initialised.
// RULE_11 - Host keeps the init select level constant while the module is present.
// RULE_12 - Presence line tied to ground inside the module.
// RULE_13 - Open-collector alert goes low on fault or critical status.
// RULE_14 - Host finds the alert source by reading the memory map.
// RULE_15 - Not-ready flag stays set until reset or power-up initialisation ends.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module msc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic initialization_control_select,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic presence_detect_n,
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic init_pullup_en,
  output logic high_power_mode,
  output logic irq
);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic sel_s1;
    logic sel_s2;
    logic mode_s1;
    logic mode_s2;
    msc_pkg::msc_seq_e seq;
    logic [15:0] init_cnt;
    logic [15:0] low_cnt;
    logic not_ready;
    logic hp_enable;
    logic high_power;
    logic alert_done;
    logic alert_fault;
    logic [msc_pkg::IRQ_W-1:0] irq_status;
    logic [msc_pkg::IRQ_W-1:0] irq_enable;
    logic [31:0] prdata;
  } msc_state_s;

  msc_state_s s;
  msc_state_s next_s;

  logic tw_wr;
  logic tw_rd;
  logic [7:0] tw_addr;
  logic [7:0] tw_wdata;
  logic [7:0] tw_rdata;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic full_reset;
  logic fault_req;
  logic [msc_pkg::IRQ_W-1:0] irq_ev;

  // 2-wire slave, gated by the synchronised select level
  msc_twi_slave u_twi (
    .pclk(pclk),
    .presetn(presetn),
    .en(~s.sel_s2), // see RULE_01
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .reg_wr(tw_wr),
    .reg_rd(tw_rd),
    .reg_addr(tw_addr),
    .reg_wdata(tw_wdata),
    .reg_rdata(tw_rdata)
  );

  // APB decode; zero wait states, unknown offsets answer with an error
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == msc_pkg::OFS_IRQ_STATUS) || (paddr == msc_pkg::OFS_IRQ_CLEAR) ||
                  (paddr == msc_pkg::OFS_IRQ_ENABLE) || (paddr == msc_pkg::OFS_STATE) ||
                  (paddr == msc_pkg::OFS_CONTROL);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.prdata;

  // Reset pin held past the minimum: flag only once the full length is seen
  assign full_reset = ~s.rst_s2 && (s.low_cnt == msc_pkg::RST_CYC); // see RULE_04
  assign fault_req = wr_acc && (paddr == msc_pkg::OFS_CONTROL) && pwdata[msc_pkg::CTRL_FAULT];

  // Memory map as the host sees it over the 2-wire bus
  always_comb begin
    unique case (tw_addr)
      msc_pkg::MAP_STATUS: tw_rdata = {5'h00, s.mode_s2, s.high_power, s.not_ready};
      msc_pkg::MAP_CONTROL: tw_rdata = {7'h00, s.hp_enable};
      msc_pkg::MAP_ALERT: tw_rdata = {6'h00, s.alert_fault, s.alert_done}; // see RULE_13
      default: tw_rdata = 8'h00;
    endcase
  end

  // Sequencer, flags and register file
  always_comb begin
    next_s = s;
    irq_ev = '0;
    // Pins from the host are asynchronous: two flops before any use
    next_s.rst_s1 = module_reset_n;
    next_s.rst_s2 = s.rst_s1;
    next_s.sel_s1 = module_select_n;
    next_s.sel_s2 = s.sel_s1;
    next_s.mode_s1 = initialization_control_select;
    next_s.mode_s2 = s.mode_s1;

    // Length of the current low pulse on the reset pin, saturating
    if (s.rst_s2) begin
      next_s.low_cnt = 16'h0000;
    end else if (s.low_cnt != msc_pkg::RST_CYC) begin
      next_s.low_cnt = s.low_cnt + 16'h0001;
    end

    // Host writes over the 2-wire bus; only the power enable is writable
    if (tw_wr && tw_addr == msc_pkg::MAP_CONTROL) begin
      next_s.hp_enable = tw_wdata[0]; // see RULE_09
    end
    irq_ev[msc_pkg::IRQ_HOST_WRITE] = tw_wr;

    // Alert sources clear when the host reads them; a new event wins
    if (tw_rd && tw_addr == msc_pkg::MAP_ALERT) begin
      next_s.alert_done = 1'b0;
      next_s.alert_fault = 1'b0;
    end
    if (fault_req) begin
      next_s.alert_fault = 1'b1; // see RULE_13
    end

    unique case (s.seq)
      msc_pkg::SEQ_INIT: begin
        // Startup count waits for the reset pin to go high again
        next_s.not_ready = 1'b1; // see RULE_15
        next_s.high_power = 1'b0;
        if (!s.rst_s2) begin
          next_s.init_cnt = 16'h0000;
        end else if (s.init_cnt == msc_pkg::INIT_CYC - 16'h0001) begin
          next_s.seq = msc_pkg::SEQ_READY;
          next_s.not_ready = 1'b0; // see RULE_15
          next_s.alert_done = 1'b1; // see RULE_06
          irq_ev[msc_pkg::IRQ_RESET_DONE] = 1'b1;
        end else begin
          next_s.init_cnt = s.init_cnt + 16'h0001;
        end
      end
      msc_pkg::SEQ_READY: begin
        // Init select high: software decides; low: straight to high power
        if (s.mode_s2) begin
          next_s.high_power = s.hp_enable; // see RULE_09
        end else begin
          next_s.high_power = 1'b1; // see RULE_10
        end
      end
    endcase

    // Complete reset returns every sideband setting to its default; the APB interrupt status and enable keep their values
    if (full_reset) begin
      next_s.seq = msc_pkg::SEQ_INIT; // see RULE_04
      next_s.init_cnt = 16'h0000;
      next_s.not_ready = 1'b1;
      next_s.hp_enable = 1'b0;
      next_s.high_power = 1'b0;
      next_s.alert_done = 1'b0;
      next_s.alert_fault = 1'b0;
    end
    irq_ev[msc_pkg::IRQ_HIGH_POWER] = next_s.high_power & ~s.high_power;

    // Sticky status: clear first, then events so a same-cycle set wins
    if (wr_acc && paddr == msc_pkg::OFS_IRQ_CLEAR) begin
      next_s.irq_status = s.irq_status & ~pwdata[msc_pkg::IRQ_W-1:0];
    end
    next_s.irq_status = next_s.irq_status | irq_ev;
    if (wr_acc && paddr == msc_pkg::OFS_IRQ_ENABLE) begin
      next_s.irq_enable = pwdata[msc_pkg::IRQ_W-1:0];
    end

    // Read data captured in the setup cycle, held through access
    if (rd_setup) begin
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        msc_pkg::OFS_IRQ_STATUS: next_s.prdata[msc_pkg::IRQ_W-1:0] = s.irq_status;
        msc_pkg::OFS_IRQ_ENABLE: next_s.prdata[msc_pkg::IRQ_W-1:0] = s.irq_enable;
        msc_pkg::OFS_STATE: begin
          next_s.prdata[msc_pkg::ST_NOT_READY] = s.not_ready;
          next_s.prdata[msc_pkg::ST_HIGH_POWER] = s.high_power;
          next_s.prdata[msc_pkg::ST_INIT_SEL] = s.mode_s2;
          next_s.prdata[msc_pkg::ST_SELECTED] = ~s.sel_s2;
          next_s.prdata[msc_pkg::ST_RESET_PIN] = s.rst_s2;
          next_s.prdata[msc_pkg::ST_READY] = (s.seq == msc_pkg::SEQ_READY);
        end
        msc_pkg::OFS_CONTROL: next_s.prdata[msc_pkg::CTRL_FAULT] = s.alert_fault;
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
  end

  // Power-up reset lands in the init state, so completion follows unasked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{rst_s1: 1'b1, rst_s2: 1'b1, sel_s1: 1'b1, sel_s2: 1'b1, mode_s1: 1'b1,
             mode_s2: 1'b1, seq: msc_pkg::SEQ_INIT, not_ready: 1'b1,
             irq_enable: msc_pkg::IRQ_ENABLE_RST, default: '0}; // see RULE_07
    end else begin
      s <= next_s;
    end
  end

  // Pin drivers; open-collector lines only ever pull low
  assign sda_out = 1'b0;
  assign alert_n_out = 1'b0;
  assign alert_n_oe = s.alert_done | s.alert_fault; // see RULE_06
  assign presence_detect_n = 1'b0; // see RULE_12
  assign init_pullup_en = 1'b1; // see RULE_08
  assign high_power_mode = s.high_power;
  assign irq = |(s.irq_status & s.irq_enable);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_reset: assert property (full_reset |=> s.not_ready && !s.hp_enable && !alert_n_oe) // see RULE_04
    else $error("long reset pulse did not restore defaults");
  a_done_alert: assert property ($fell(s.not_ready) |-> alert_n_oe) // see RULE_06
    else $error("ready without completion alert");
  a_init_length: assert property ((s.seq == msc_pkg::SEQ_INIT && s.rst_s2 && s.init_cnt == 16'h0000)
    ##1 (s.rst_s2 throughout ##248 1'b1) |=> !s.not_ready) // see RULE_07
    else $error("initialisation did not complete on time");
  a_pullup_on: assert property (init_pullup_en) // see RULE_08
    else $error("init select pull-up released");
  a_sw_low_power: assert property (s.mode_s2 && !s.hp_enable |=> !high_power_mode) // see RULE_09
    else $error("high power without software enable");
  a_hw_high_power: assert property (s.seq == msc_pkg::SEQ_READY && !s.mode_s2 && s.rst_s2
    |=> high_power_mode) // see RULE_10
    else $error("hardware control did not enter high power");
  a_present_low: assert property (!presence_detect_n) // see RULE_12
    else $error("presence line not grounded");
  a_fault_alert: assert property (fault_req && !full_reset |=> alert_n_oe ##1 !alert_n_out) // see RULE_13
    else $error("fault did not raise alert");
  a_not_ready_init: assert property (s.seq == msc_pkg::SEQ_INIT |-> s.not_ready) // see RULE_15
    else $error("not-ready flag clear during initialisation");

endmodule // msc_top

/* design/msc_twi_slave.sv */
// Byte-oriented 2-wire slave giving access to the sideband memory map
`timescale 1ns/1ps
module msc_twi_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    msc_pkg::msc_tw_e st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic rack;
    logic oe;
    logic wr;
    logic rd;
  } msc_tw_s;

  msc_tw_s s;
  msc_tw_s next_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // Edge and condition detect on synchronised copies only
  assign rise = s.scl_s2 & ~s.scl_p;
  assign fall = ~s.scl_s2 & s.scl_p;
  assign start = s.scl_s2 & s.scl_p & s.sda_p & ~s.sda_s2;
  assign stop = s.scl_s2 & s.scl_p & ~s.sda_p & s.sda_s2;

  // Bit engine; drives the data line only low, never high
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    next_s.scl_s1 = scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_p = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_p = s.sda_s2;
    if (!en || stop) begin // see RULE_01
      next_s.st = msc_pkg::TW_IDLE;
      next_s.oe = 1'b0;
    end else if (start) begin
      next_s.st = msc_pkg::TW_ADDR;
      next_s.bitc = 4'h0;
      next_s.oe = 1'b0;
    end else begin
      unique case (s.st)
        msc_pkg::TW_IDLE: begin
          next_s.oe = 1'b0;
        end
        msc_pkg::TW_ADDR, msc_pkg::TW_PTR, msc_pkg::TW_WDATA: begin
          if (rise) begin
            next_s.sh = {s.sh[6:0], s.sda_s2};
            next_s.bitc = s.bitc + 4'h1;
          end else if (fall && s.bitc == msc_pkg::TW_BYTE_BITS) begin
            next_s.bitc = 4'h0;
            if (s.st == msc_pkg::TW_ADDR) begin
              // Foreign addresses drop back to idle without acknowledge
              if (s.sh[7:1] == msc_pkg::DEV_ADDR) begin
                next_s.rw = s.sh[0];
                next_s.oe = 1'b1;
                next_s.st = msc_pkg::TW_ACK_A;
              end else begin
                next_s.st = msc_pkg::TW_IDLE;
              end
            end else if (s.st == msc_pkg::TW_PTR) begin
              next_s.ptr = s.sh;
              next_s.oe = 1'b1;
              next_s.st = msc_pkg::TW_ACK_P;
            end else begin
              next_s.wr = 1'b1; // see RULE_03
              next_s.oe = 1'b1;
              next_s.st = msc_pkg::TW_ACK_D;
            end
          end
        end
        msc_pkg::TW_ACK_A, msc_pkg::TW_ACK_P, msc_pkg::TW_ACK_D: begin
          if (fall) begin
            next_s.oe = 1'b0;
            if (s.st == msc_pkg::TW_ACK_A && s.rw) begin
              next_s.sh = reg_rdata; // see RULE_03
              next_s.rd = 1'b1;
              next_s.oe = ~reg_rdata[7];
              next_s.rack = 1'b0;
              next_s.st = msc_pkg::TW_RDATA;
            end else if (s.st == msc_pkg::TW_ACK_A) begin
              next_s.st = msc_pkg::TW_PTR;
            end else begin
              // Auto increment after each data byte
              if (s.st == msc_pkg::TW_ACK_D) begin
                next_s.ptr = s.ptr + 8'h01;
              end
              next_s.st = msc_pkg::TW_WDATA;
            end
          end
        end
        msc_pkg::TW_RDATA: begin
          // rack marks the master acknowledge slot after the eighth bit
          if (s.rack) begin
            if (rise && s.sda_s2) begin
              next_s.st = msc_pkg::TW_IDLE;
            end else if (fall) begin
              next_s.sh = reg_rdata;
              next_s.rd = 1'b1;
              next_s.oe = ~reg_rdata[7];
              next_s.rack = 1'b0;
            end
          end else if (fall) begin
            if (s.bitc == msc_pkg::TW_LAST_BIT) begin
              next_s.oe = 1'b0;
              next_s.ptr = s.ptr + 8'h01;
              next_s.bitc = 4'h0;
              next_s.rack = 1'b1;
            end else begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.oe = ~s.sh[6];
              next_s.bitc = s.bitc + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // State register; lines idle high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             sda_p: 1'b1, st: msc_pkg::TW_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign sda_oe = s.oe;
  assign reg_wr = s.wr;
  assign reg_rd = s.rd;
  assign reg_addr = s.ptr;
  assign reg_wdata = s.sh;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_select_gate: assert property (!en |=> !sda_oe) // see RULE_01
    else $error("data line driven while not selected");
  a_write_ack: assert property (reg_wr |-> sda_oe && s.st == msc_pkg::TW_ACK_D) // see RULE_03
    else $error("map write without acknowledge");

endmodule // msc_twi_slave

/* verif/msc_host_model.sv */
// Host board model: 2-wire master driving SCL directly, with a board pull-up on SDA
`timescale 1ns/1ps
module msc_host_model (
  output logic scl,
  output logic sda_in,
  input wire logic sda_oe
);
  // Quarter of the 125 ns link clock; SCL stands high between frames
  localparam real Q = 31.25;
  logic pull_sda;

  // Open-drain SDA: nobody pulling means the pull-up wins
  assign sda_in = ~(pull_sda | sda_oe);

  initial begin
    scl = 1'b1;
    pull_sda = 1'b0;
  end

  task automatic put_bit(input logic b);
    pull_sda = ~b;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
    #Q;
  endtask

  // Sample in the middle of SCL high, well after the slave moved
  task automatic get_bit(output logic b);
    pull_sda = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda_in;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Also serves as repeated start, since SCL may be low on entry
  task automatic start_cond();
    pull_sda = 1'b0;
    #Q scl = 1'b1;
    #Q pull_sda = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop_cond();
    pull_sda = 1'b1;
    #Q scl = 1'b1;
    #Q pull_sda = 1'b0;
    #Q;
  endtask

  // MSB first, then the slave's acknowledge bit (0 = acked)
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask

  task automatic tw_wr(input logic [7:0] ptr, input logic [7:0] d, output logic nack);
    logic a0, a1, a2;
    start_cond();
    send_byte(8'ha0, a0);
    send_byte(ptr, a1);
    send_byte(d, a2);
    stop_cond();
    nack = a0 | a1 | a2;
  endtask

  // Host finds alert sources by reading the map
  task automatic tw_rd(input logic [7:0] ptr, output logic [7:0] d, output logic nack);
    logic a0, a1, a2;
    start_cond();
    send_byte(8'ha0, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte(8'ha1, a2);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop_cond();
    nack = a0 | a1 | a2;
  endtask
endmodule // msc_host_model

/* verif/msc_top_bench.sv */
// Self-checking bench for the module sideband control block
`timescale 1ns/1ps
module msc_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl, sda_in, sda_oe, presence_detect_n, alert_n_out;
  logic alert_n_oe, init_pullup_en, high_power_mode, irq, er, ack;
  logic sel_n = 1'b1, rst_pin_n = 1'b1, init_drv = 1'b0, init_val = 1'b0;
  logic [7:0] tb;
  int err_count = 0, tests_run = 0, m_stat, m_en;
  // Board side: pull-up on init select, pull-up on the open-collector alert
  wire init_wire = init_drv ? init_val : init_pullup_en;
  wire alert_wire = ~(alert_n_oe & ~alert_n_out);

  always #2 pclk = ~pclk;

  msc_top msc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_select_n(sel_n), .module_reset_n(rst_pin_n),
    .initialization_control_select(init_wire), .scl(scl), .sda_in(sda_in), .sda_out(),
    .sda_oe(sda_oe), .presence_detect_n(presence_detect_n), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .init_pullup_en(init_pullup_en),
    .high_power_mode(high_power_mode), .irq(irq));

  msc_host_model msc_host_model_inst (.scl(scl), .sda_in(sda_in), .sda_oe(sda_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // APB transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample ready and the answer at the rising edge that ends the access
    for (int i = 0; i < 16 && !done; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        rd = prdata;
        er = pslverr;
        done = 1'b1;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Bounded wait: which 0 watches the alert enable, 1 the power mode
  task automatic wait_for(input int which, input logic lvl, input int max);
    int i;
    logic v;
    for (i = 0; i < max; i++) begin
      @(negedge pclk);
      v = which ? high_power_mode : alert_n_oe;
      if (v === lvl) break;
    end
    if (i == max) begin
      err_count++;
      report_and_stop();
    end
  endtask

  // Watchdog against a hung 2-wire transfer
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hf637f22e));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Power-up: not ready first, then completion alert with no pin pulse
    apb(1'b0, msc_pkg::OFS_STATE, 32'h0);
    check(rd[msc_pkg::ST_NOT_READY], 1'b1);
    check(presence_detect_n, 1'b0);
    wait_for(0, 1'b1, 400);
    check(alert_wire, 1'b0);
    m_stat = 1;
    m_en = 0;
    rd_chk(msc_pkg::OFS_STATE, 32'h34);
    rd_chk(msc_pkg::OFS_IRQ_STATUS, m_stat);
    rd_chk(msc_pkg::OFS_IRQ_ENABLE, m_en);
    $display("test power_up done");
    // Interrupt raise, mask, clear, read-only and unmapped places
    m_en = ($urandom() & 7) | 1;
    apb(1'b1, msc_pkg::OFS_IRQ_ENABLE, m_en);
    rd_chk(msc_pkg::OFS_IRQ_ENABLE, m_en);
    check(irq, (m_stat & m_en) != 0);
    apb(1'b1, msc_pkg::OFS_IRQ_ENABLE, 32'h0);
    @(negedge pclk);
    check(irq, 1'b0);
    apb(1'b1, msc_pkg::OFS_IRQ_CLEAR, 32'h1);
    m_stat = 0;
    apb(1'b1, msc_pkg::OFS_IRQ_STATUS, 32'hffffffff);
    rd_chk(msc_pkg::OFS_IRQ_STATUS, m_stat);
    rd_chk(msc_pkg::OFS_IRQ_CLEAR, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check({rd[30:0], er}, 32'h1);
    m_en = 7;
    apb(1'b1, msc_pkg::OFS_IRQ_ENABLE, m_en);
    $display("test interrupts done");
    // 2-wire ignored while deselected, then map access once selected
    msc_host_model_inst.tw_wr(8'h01, 8'h01, ack);
    check(ack, 1'b1);
    check(high_power_mode, 1'b0);
    @(posedge pclk);
    sel_n <= 1'b0;
    repeat (4) @(posedge pclk);
    msc_host_model_inst.tw_rd(8'h02, tb, ack);
    check({ack, tb}, 9'h001);
    @(negedge pclk);
    check(alert_n_oe, 1'b0);
    msc_host_model_inst.tw_rd(8'h00, tb, ack);
    check({ack, tb}, 9'h004);
    msc_host_model_inst.tw_wr(8'h01, 8'h01, ack);
    check(ack, 1'b0);
    wait_for(1, 1'b1, 300);
    m_stat = 6;
    rd_chk(msc_pkg::OFS_IRQ_STATUS, m_stat);
    check(irq, (m_stat & m_en) != 0);
    msc_host_model_inst.tw_rd(8'h00, tb, ack);
    check({ack, tb}, 9'h006);
    $display("test two_wire done");
    // Software fault raises the alert until the host reads the sources
    apb(1'b1, msc_pkg::OFS_CONTROL, 32'h1);
    wait_for(0, 1'b1, 20);
    check(alert_wire, 1'b0);
    rd_chk(msc_pkg::OFS_CONTROL, 32'h1);
    msc_host_model_inst.tw_rd(8'h02, tb, ack);
    check({ack, tb}, 9'h002);
    @(negedge pclk);
    check(alert_n_oe, 1'b0);
    $display("test fault done");
    // Short reset pulse does nothing; a long one resets to defaults
    @(posedge pclk);
    rst_pin_n <= 1'b0;
    repeat (100) @(posedge pclk);
    rst_pin_n <= 1'b1;
    repeat (300) @(posedge pclk);
    check(high_power_mode, 1'b1);
    rst_pin_n <= 1'b0;
    repeat (600) @(posedge pclk);
    apb(1'b0, msc_pkg::OFS_STATE, 32'h0);
    check({rd[msc_pkg::ST_NOT_READY], high_power_mode}, 2'b10);
    rst_pin_n <= 1'b1;
    wait_for(0, 1'b1, 400);
    apb(1'b0, msc_pkg::OFS_STATE, 32'h0);
    check(rd[msc_pkg::ST_NOT_READY], 1'b0);
    msc_host_model_inst.tw_rd(8'h01, tb, ack);
    check({ack, tb}, 9'h000);
    $display("test reset_pin done");
    // Hardware control: init select low, level set only while held in reset
    @(posedge pclk);
    presetn <= 1'b0;
    init_drv <= 1'b1;
    init_val <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(1, 1'b1, 400);
    check(high_power_mode, 1'b1);
    $display("test hardware_mode done");
    report_and_stop();
  end
endmodule // msc_top_bench
